/* popb_pkg.sv */
// Function
// - Open line when current exceeds upper limit
// - Sample current at programmable monitoring interval
// - Auto reclose tripped lines at programmed interval
// - One common modulation period in microseconds
// - Per-line mode: off, rise, fall, both, free
// - Free-running lines ignore output writes
// - Per-line duty fraction for free-running lines
// - Per-line ramp train length in microseconds
// - Rise ramp on write 1 after 0
// - Fall ramp on write 0 after 1
// - Both-edges ramps either way; off none
// - Limits enforced only on unmodulated lines
// - Trip when current outside programmed limits
// - Common limit at session; edits only before run
// - Live breaker word, bit n line n
// - Sticky breaker word cleared by status read
// - Mask reset: ones reset, zeros untouched
// - Diag channels 0-31 current, 32-63 voltage
// - Reduced variant reads current only
// - Session start resets all breakers
// - Mask bit n selects line n
package popb_pkg;
  localparam int NUM_LINES     = 32;
  localparam int LINE_W        = 5;
  localparam int ADC_W         = 12;
  localparam int DUTY_W        = 8;
  localparam int LEN_W         = 16;
  localparam int US_W          = 16;
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US     = 1000;
  localparam int CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;
  localparam int PRE_W         = 7;
  localparam int PHASE_W       = 23;
  localparam int PD_W          = PHASE_W + DUTY_W;
  localparam int DIAG_SEL_W    = 6;

  localparam logic [PRE_W-1:0]  PRE_LAST  = PRE_W'(CYC_PER_US - 1);
  localparam logic [DUTY_W-1:0] RAMP_DUTY = 8'h80;
  localparam logic [ADC_W-1:0]  LIMIT_RST = 12'hfff;
  localparam logic [LEN_W-1:0]  LEN_RST   = 16'h0000;

  typedef enum logic [2:0] {
    MODULATION_OFF      = 3'h0,
    RAMP_ON_RISE        = 3'h1,
    RAMP_ON_FALL        = 3'h2,
    RAMP_ON_BOTH_EDGES  = 3'h3,
    FREE_RUNNING_PULSES = 3'h4
  } popb_mode_t;

  typedef logic [NUM_LINES-1:0][ADC_W-1:0] popb_adc_t;

  typedef struct packed {
    logic [LINE_W-1:0] line;
    popb_mode_t        mode;
    logic [DUTY_W-1:0] duty;
    logic [LEN_W-1:0]  length;
  } popb_cfg_t;

  typedef struct packed {
    logic [LINE_W-1:0] line;
    logic [ADC_W-1:0]  upper_current_threshold;
  } popb_limit_t;

  typedef struct packed {
    logic [US_W-1:0] period_us;
    logic [US_W-1:0] monitor_sample_rate;
    logic [US_W-1:0] reclose_interval;
  } popb_time_t;
endpackage

/* popb_timebase.sv */
`timescale 1ns/1ps
module popb_timebase (
  input  wire logic                           core_clk_i,
  input  wire logic                           rst_i,
  input  wire popb_pkg::popb_time_t           time_cfg_i,
  output logic                                us_tick_o,
  output logic                                sample_tick_o,
  output logic                                reclose_tick_o,
  output logic       [popb_pkg::PHASE_W-1:0]  phase_o,
  output logic       [popb_pkg::PHASE_W-1:0]  period_cyc_o
);
  import popb_pkg::*;

  typedef struct packed {
    logic [PRE_W-1:0]   pre;
    logic [PHASE_W-1:0] phase;
    logic [PHASE_W-1:0] period_cyc;
    logic [US_W-1:0]    samp;
    logic [US_W-1:0]    recl;
    logic               us_tick;
    logic               sample_tick;
    logic               reclose_tick;
  } popb_tb_state_t;

  popb_tb_state_t q, d;

  always_comb begin
    d = q;
    d.us_tick      = 1'b0;
    d.sample_tick  = 1'b0;
    d.reclose_tick = 1'b0;
    // Shared period for all lines, in clock cycles
    d.period_cyc = PHASE_W'(time_cfg_i.period_us) * PHASE_W'(CYC_PER_US);
    if (q.pre >= PRE_LAST) begin
      d.pre     = '0;
      d.us_tick = 1'b1;
    end else begin
      d.pre = q.pre + 1'b1;
    end
    if (q.period_cyc == '0 || q.phase >= q.period_cyc - 1'b1) begin
      d.phase = '0;
    end else begin
      d.phase = q.phase + 1'b1;
    end
    if (q.us_tick) begin
      if (q.samp + 1'b1 >= time_cfg_i.monitor_sample_rate) begin
        d.samp        = '0;
        d.sample_tick = 1'b1;
      end else begin
        d.samp = q.samp + 1'b1;
      end
      if (q.recl + 1'b1 >= time_cfg_i.reclose_interval) begin
        d.recl         = '0;
        d.reclose_tick = 1'b1;
      end else begin
        d.recl = q.recl + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign us_tick_o      = q.us_tick;
  assign sample_tick_o  = q.sample_tick;
  assign reclose_tick_o = q.reclose_tick;
  assign phase_o        = q.phase;
  assign period_cyc_o   = q.period_cyc;
endmodule

/* popb_breaker.sv */
`timescale 1ns/1ps
module popb_breaker #(
  parameter bit VOLT_MON = 1'b1
) (
  input  wire logic                              core_clk_i,
  input  wire logic                              rst_i,
  // Timing and mode configuration
  input  wire popb_pkg::popb_time_t              time_cfg_i,
  input  wire logic                              cfg_wr_i,
  input  wire popb_pkg::popb_cfg_t               cfg_i,
  input  wire logic      [popb_pkg::LINE_W-1:0]  cfg_rd_line_i,
  // Session control and limits
  input  wire logic                              session_start_i,
  input  wire logic                              op_start_i,
  input  wire logic      [popb_pkg::ADC_W-1:0]   common_limit_i,
  input  wire logic      [popb_pkg::ADC_W-1:0]   lower_current_threshold_i,
  input  wire logic                              limit_wr_i,
  input  wire popb_pkg::popb_limit_t             limit_i,
  input  wire logic                              reclose_enable_i,
  // Output data
  input  wire logic                              out_wr_i,
  input  wire logic      [popb_pkg::NUM_LINES-1:0] out_data_i,
  // Measurements from the monitor converter
  input  wire popb_pkg::popb_adc_t               meas_current_i,
  input  wire popb_pkg::popb_adc_t               meas_voltage_i,
  // Breaker access
  input  wire logic                              status_rd_i,
  input  wire logic                              breaker_reset_i,
  input  wire logic      [popb_pkg::NUM_LINES-1:0] breaker_mask_i,
  input  wire logic      [popb_pkg::DIAG_SEL_W-1:0] diag_sel_i,
  // Outputs
  output logic           [popb_pkg::NUM_LINES-1:0] line_o,
  output logic           [popb_pkg::NUM_LINES-1:0] breaker_status_o,
  output logic           [popb_pkg::NUM_LINES-1:0] breaker_sticky_o,
  output logic           [popb_pkg::ADC_W-1:0]   diag_data_o,
  output logic                                   diag_valid_o,
  output logic                                   running_o,
  output logic                                   limit_refused_o,
  output popb_pkg::popb_cfg_t                    cfg_rd_o,
  output logic           [popb_pkg::ADC_W-1:0]   limit_rd_o
);
  import popb_pkg::*;

  typedef struct packed {
    logic [NUM_LINES-1:0][2:0]        mode;
    logic [NUM_LINES-1:0][DUTY_W-1:0] duty;
    logic [NUM_LINES-1:0][LEN_W-1:0]  len;
    logic [NUM_LINES-1:0][LEN_W-1:0]  ramp;
    logic [NUM_LINES-1:0][ADC_W-1:0]  upper;
    logic [NUM_LINES-1:0]             out;
    logic [NUM_LINES-1:0]             tripped;
    logic [NUM_LINES-1:0]             sticky;
    logic [NUM_LINES-1:0]             line;
    logic                             running;
    logic                             limit_refused;
    logic [ADC_W-1:0]                 diag;
    logic                             diag_valid;
    popb_cfg_t                        cfg_rd;
    logic [ADC_W-1:0]                 limit_rd;
  } popb_state_t;

  popb_state_t q, d;

  logic               us_tick;
  logic               sample_tick;
  logic               reclose_tick;
  logic [PHASE_W-1:0] phase;
  logic [PHASE_W-1:0] period_cyc;

  popb_timebase u_timebase (
    .core_clk_i     (core_clk_i),
    .rst_i          (rst_i),
    .time_cfg_i     (time_cfg_i),
    .us_tick_o      (us_tick),
    .sample_tick_o  (sample_tick),
    .reclose_tick_o (reclose_tick),
    .phase_o        (phase),
    .period_cyc_o   (period_cyc)
  );

  // High part of a pulse: phase / period below duty / 256
  function automatic logic pwm_high(
    input logic [PHASE_W-1:0] ph,
    input logic [PHASE_W-1:0] per,
    input logic [DUTY_W-1:0]  duty
  );
    logic [PD_W-1:0] lhs;
    logic [PD_W-1:0] rhs;
    lhs = {ph, {DUTY_W{1'b0}}};
    rhs = PD_W'(per) * PD_W'(duty);
    return lhs < rhs;
  endfunction

  // Current inside the window of lower and upper threshold
  function automatic logic in_limits(
    input logic [ADC_W-1:0] cur,
    input logic [ADC_W-1:0] up,
    input logic [ADC_W-1:0] lo
  );
    return (cur <= up) && (cur >= lo);
  endfunction

  always_comb begin
    logic       rise;
    logic       fall;
    logic       ramp_trig;
    logic       trip_evt;
    logic       clr;
    logic       drive;
    popb_mode_t m;
    rise      = 1'b0;
    fall      = 1'b0;
    ramp_trig = 1'b0;
    trip_evt  = 1'b0;
    clr       = 1'b0;
    drive     = 1'b0;
    m         = MODULATION_OFF;
    d = q;
    d.limit_refused = 1'b0;

    // Per-line configuration
    if (cfg_wr_i) begin
      d.mode[cfg_i.line] = cfg_i.mode;
      d.duty[cfg_i.line] = cfg_i.duty;
      d.len[cfg_i.line]  = cfg_i.length;
    end

    // Per-line limit edits are only honoured before operation
    if (limit_wr_i) begin
      if (q.running) begin
        d.limit_refused = 1'b1;
      end else begin
        d.upper[limit_i.line] = limit_i.upper_current_threshold;
      end
    end
    if (op_start_i) begin
      d.running = 1'b1;
    end

    for (int i = 0; i < NUM_LINES; i++) begin
      m         = popb_mode_t'(q.mode[i]);
      rise      = out_data_i[i] & ~q.out[i];
      fall      = ~out_data_i[i] & q.out[i];
      ramp_trig = 1'b0;

      if (us_tick && q.ramp[i] != '0) begin
        d.ramp[i] = q.ramp[i] - 1'b1;
      end

      if (out_wr_i && m != FREE_RUNNING_PULSES) begin
        if (rise && (m == RAMP_ON_RISE || m == RAMP_ON_BOTH_EDGES)) begin
          ramp_trig = 1'b1;
        end
        if (fall && (m == RAMP_ON_FALL || m == RAMP_ON_BOTH_EDGES)) begin
          ramp_trig = 1'b1;
        end
        if (ramp_trig) begin
          d.ramp[i] = q.len[i];
        end
        d.out[i] = out_data_i[i];
      end
      if (m == MODULATION_OFF) begin
        d.ramp[i] = '0;
      end

      // Breaker: trip only for plain outputs, on a sample tick
      trip_evt = sample_tick && m == MODULATION_OFF && !q.tripped[i] &&
                 !in_limits(meas_current_i[i], q.upper[i],
                            lower_current_threshold_i);
      clr = (breaker_reset_i && breaker_mask_i[i]) ||
            (reclose_tick && reclose_enable_i && q.tripped[i] &&
             in_limits(meas_current_i[i], q.upper[i],
                       lower_current_threshold_i)) ||
            session_start_i;
      d.tripped[i] = trip_evt || (q.tripped[i] && !clr);
      d.sticky[i]  = trip_evt || (q.sticky[i] && !status_rd_i);

      // Line drive
      if (q.tripped[i]) begin
        drive = 1'b0;
      end else if (m == FREE_RUNNING_PULSES) begin
        drive = pwm_high(phase, period_cyc, q.duty[i]);
      end else if (q.ramp[i] != '0) begin
        drive = pwm_high(phase, period_cyc, RAMP_DUTY);
      end else begin
        drive = q.out[i];
      end
      d.line[i] = drive;
    end

    // New session: common limit everywhere, stop operation
    if (session_start_i) begin
      d.upper   = {NUM_LINES{common_limit_i}};
      d.running = 1'b0;
    end

    // Diagnostic readback
    if (!diag_sel_i[DIAG_SEL_W-1]) begin
      d.diag       = meas_current_i[diag_sel_i[LINE_W-1:0]];
      d.diag_valid = 1'b1;
    end else if (VOLT_MON) begin
      d.diag       = meas_voltage_i[diag_sel_i[LINE_W-1:0]];
      d.diag_valid = 1'b1;
    end else begin
      d.diag       = '0;
      d.diag_valid = 1'b0;
    end

    // Configuration readback
    d.cfg_rd.line   = cfg_rd_line_i;
    d.cfg_rd.mode   = popb_mode_t'(q.mode[cfg_rd_line_i]);
    d.cfg_rd.duty   = q.duty[cfg_rd_line_i];
    d.cfg_rd.length = q.len[cfg_rd_line_i];
    d.limit_rd      = q.upper[cfg_rd_line_i];
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q       <= '0;
      q.upper <= {NUM_LINES{LIMIT_RST}};
      q.len   <= {NUM_LINES{LEN_RST}};
    end else begin
      q <= d;
    end
  end

  assign line_o           = q.line;
  assign breaker_status_o = q.tripped;
  assign breaker_sticky_o = q.sticky;
  assign diag_data_o      = q.diag;
  assign diag_valid_o     = q.diag_valid;
  assign running_o        = q.running;
  assign limit_refused_o  = q.limit_refused;
  assign cfg_rd_o         = q.cfg_rd;
  assign limit_rd_o       = q.limit_rd;
endmodule

/* popb_breaker_props.sv */
`timescale 1ns/1ps
module popb_breaker_props import popb_pkg::*; #(
  parameter bit VOLT_MON = 1'b1
) (
  input wire logic                  core_clk_i,
  input wire logic                  rst_i,
  input wire logic                  session_start_i,
  input wire logic                  op_start_i,
  input wire logic                  limit_wr_i,
  input wire logic                  status_rd_i,
  input wire logic                  breaker_reset_i,
  input wire logic [NUM_LINES-1:0]  breaker_mask_i,
  input wire logic [DIAG_SEL_W-1:0] diag_sel_i,
  input wire popb_adc_t             meas_current_i,
  input wire logic [NUM_LINES-1:0]  line_o,
  input wire logic [NUM_LINES-1:0]  breaker_status_o,
  input wire logic [NUM_LINES-1:0]  breaker_sticky_o,
  input wire logic [ADC_W-1:0]      diag_data_o,
  input wire logic                  diag_valid_o,
  input wire logic                  running_o,
  input wire logic                  limit_refused_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  trip_opens_a: assert property (
    (breaker_status_o & $past(breaker_status_o) & line_o) == '0)
    else $error("tripped line driven");
  sticky_set_a: assert property (
    (breaker_status_o & ~$past(breaker_status_o) & ~breaker_sticky_o) == '0)
    else $error("trip missing in sticky word");
  sticky_read_a: assert property (
    $past(status_rd_i) |-> (breaker_sticky_o & $past(breaker_status_o)) == '0)
    else $error("sticky not cleared by read");
  sticky_keep_a: assert property (
    !$past(status_rd_i) |-> ($past(breaker_sticky_o) & ~breaker_sticky_o) == '0)
    else $error("sticky dropped without read");
  mask_reset_a: assert property (
    $past(breaker_reset_i) |->
      (breaker_status_o & $past(breaker_status_o & breaker_mask_i)) == '0)
    else $error("masked breaker not reset");
  session_clear_a: assert property (
    $past(session_start_i) |->
      !running_o && (breaker_status_o & $past(breaker_status_o)) == '0)
    else $error("session start did not clear");
  limit_refuse_a: assert property (
    limit_refused_o == $past(limit_wr_i && running_o))
    else $error("limit refusal wrong");
  run_start_a: assert property (
    $past(op_start_i && !session_start_i) |-> running_o)
    else $error("operation not started");
  diag_valid_a: assert property (
    !$past(rst_i) |-> diag_valid_o == (!$past(diag_sel_i[5]) || VOLT_MON))
    else $error("diag valid wrong");
  diag_data_a: assert property (
    !$past(diag_sel_i[5]) |->
      diag_data_o == $past(meas_current_i[diag_sel_i[4:0]]))
    else $error("diag current wrong");
endmodule
bind popb_breaker popb_breaker_props #(.VOLT_MON(VOLT_MON)) i_props (
  .core_clk_i, .rst_i, .session_start_i, .op_start_i, .limit_wr_i,
  .status_rd_i, .breaker_reset_i, .breaker_mask_i, .diag_sel_i,
  .meas_current_i, .line_o, .breaker_status_o, .breaker_sticky_o,
  .diag_data_o, .diag_valid_o, .running_o, .limit_refused_o);

/* popb_load.sv */
`timescale 1ns/1ps
module popb_load import popb_pkg::*; (
  input  wire logic [NUM_LINES-1:0] line_i,
  input  wire logic [NUM_LINES-1:0] overload_i,
  output popb_adc_t                 current_o,
  output popb_adc_t                 voltage_o
);
  // Loads draw current only while their line is closed
  always_comb begin
    for (int n = 0; n < NUM_LINES; n++) begin
      current_o[n] = !line_i[n] ? 12'h000 : overload_i[n] ? 12'h500 : 12'h100;
      voltage_o[n] = line_i[n] ? 12'h600 : 12'h000;
    end
  end
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import popb_pkg::*;
  logic        core_clk_i = 1'b0, rst_i = 1'b1;
  logic        cfg_wr_i, session_start_i, op_start_i, limit_wr_i, out_wr_i;
  logic        reclose_enable_i, status_rd_i, breaker_reset_i;
  logic        diag_valid_o, running_o, limit_refused_o;
  logic [31:0] out_data_i, breaker_mask_i, line_o, ovl;
  logic [31:0] breaker_status_o, breaker_sticky_o;
  logic [11:0] lower_current_threshold_i, diag_data_o, limit_rd_o;
  logic [4:0]  cfg_rd_line_i;
  logic [5:0]  diag_sel_i;
  popb_cfg_t   cfg_i, cfg_rd_o;
  popb_limit_t limit_i;
  popb_adc_t   meas_current_i, meas_voltage_i;
  popb_time_t  tcfg = '{16'h0002, 16'h0001, 16'h0002};
  logic        diag_valid_r;
  logic [11:0] diag_data_r;
  int          error_cnt = 0, checked = 0;
  int          hi [32];
  popb_cfg_t   modes [5] = '{'{5'd8, FREE_RUNNING_PULSES, 8'h40, 16'h0000},
    '{5'd9, RAMP_ON_RISE, 8'h00, 16'h0003},
    '{5'd10, RAMP_ON_FALL, 8'h00, 16'h0003},
    '{5'd11, RAMP_ON_BOTH_EDGES, 8'h00, 16'h0003},
    '{5'd12, MODULATION_OFF, 8'h00, 16'h0003}};

  always #5 core_clk_i = ~core_clk_i;

  popb_breaker #(.VOLT_MON(1'b1)) i_popb_breaker (
    .core_clk_i, .rst_i, .cfg_wr_i, .cfg_i, .cfg_rd_line_i,
    .time_cfg_i(tcfg), .session_start_i,
    .op_start_i, .common_limit_i(12'h400), .lower_current_threshold_i,
    .limit_wr_i, .limit_i, .reclose_enable_i, .out_wr_i, .out_data_i,
    .meas_current_i, .meas_voltage_i, .status_rd_i, .breaker_reset_i,
    .breaker_mask_i, .diag_sel_i, .line_o, .breaker_status_o,
    .breaker_sticky_o, .diag_data_o, .diag_valid_o, .running_o,
    .limit_refused_o, .cfg_rd_o, .limit_rd_o);

  popb_load i_popb_load (.line_i(line_o), .overload_i(ovl),
    .current_o(meas_current_i), .voltage_o(meas_voltage_i));

  // Reduced variant without voltage monitoring
  popb_breaker #(.VOLT_MON(1'b0)) i_popb_breaker_r (
    .core_clk_i, .rst_i, .cfg_wr_i, .cfg_i, .cfg_rd_line_i,
    .time_cfg_i(tcfg), .session_start_i, .op_start_i,
    .common_limit_i(12'h400), .lower_current_threshold_i, .limit_wr_i,
    .limit_i, .reclose_enable_i, .out_wr_i, .out_data_i, .meas_current_i,
    .meas_voltage_i, .status_rd_i, .breaker_reset_i, .breaker_mask_i,
    .diag_sel_i, .line_o(), .breaker_status_o(), .breaker_sticky_o(),
    .diag_data_o(diag_data_r), .diag_valid_o(diag_valid_r), .running_o(),
    .limit_refused_o(), .cfg_rd_o(), .limit_rd_o());

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic cmp(input logic [31:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_for(input logic [31:0] exp);
    int i;
    for (i = 0; i < 1000 && breaker_status_o !== exp; i++) cyc(1);
    if (i == 1000) begin
      error_cnt++;
      $display("wrong value at %0t: breaker wait timed out", $time);
      final_report();
    end
  endtask
  // Counts high cycles of every line over a window
  task automatic window(input int n);
    hi = '{default: 0};
    repeat (n) begin
      cyc(1);
      foreach (hi[k]) hi[k] += line_o[k];
    end
  endtask
  task automatic write_out(input logic [31:0] d);
    out_data_i = d;
    pulse(out_wr_i);
    cyc(1);
  endtask

  initial begin
    {cfg_wr_i, session_start_i, op_start_i, limit_wr_i, out_wr_i} = '0;
    {reclose_enable_i, status_rd_i, breaker_reset_i} = '0;
    {out_data_i, breaker_mask_i, ovl, cfg_i, limit_i} = '0;
    {lower_current_threshold_i, cfg_rd_line_i, diag_sel_i} = '0;
    cyc(16);
    rst_i = 1'b0;
    pulse(session_start_i);
    limit_i = '{5'd5, 12'h0c0};
    pulse(limit_wr_i);
    pulse(op_start_i);
    cmp(running_o, 1, "running");
    limit_i = '{5'd6, 12'h0c0};
    pulse(limit_wr_i);
    cmp(limit_refused_o, 1, "refused");
    cfg_rd_line_i = 5'd6;
    cyc(2);
    cmp(limit_rd_o, 12'h400, "limit 6");
    cfg_rd_line_i = 5'd5;
    cyc(2);
    cmp(limit_rd_o, 12'h0c0, "limit 5");
    $display("test limits done");
    cfg_wr_i = 1'b1;
    foreach (modes[k]) begin
      cfg_i = modes[k];
      cyc(1);
    end
    cfg_wr_i = 1'b0;
    cfg_rd_line_i = 5'd11;
    cyc(2);
    cmp(cfg_rd_o, modes[3], "cfg 11");
    write_out(32'hffff_ffdf);
    window(400);
    cmp(hi[8], 100, "free duty");
    cmp(hi[9] inside {[1:399]}, 1, "rise ramp");
    cmp(hi[10], 400, "fall line on rise");
    cmp(hi[11] inside {[1:399]}, 1, "both ramp");
    cmp(hi[12] + hi[0], 800, "off lines");
    cyc(200);
    cmp(line_o & 32'h0000_1e00, 32'h0000_1e00, "after rise");
    write_out(32'h0000_0000);
    window(400);
    cmp(hi[8], 100, "free ignores write");
    cmp(hi[9], 0, "rise line on fall");
    cmp(hi[10] inside {[1:399]}, 1, "fall ramp");
    cmp(hi[11] inside {[1:399]}, 1, "both ramp");
    cyc(200);
    cmp(line_o & 32'h0000_1e00, 0, "after fall");
    write_out(32'hffff_ffdf);
    cyc(500);
    $display("test modulation done");
    ovl = 32'h0000_0104;
    wait_for(32'h0000_0004);
    cyc(2);
    cmp(breaker_status_o, 32'h0000_0004, "trip");
    cmp(breaker_sticky_o, 32'h0000_0004, "sticky");
    cmp(line_o[2], 0, "line open");
    ovl = '0;
    cyc(500);
    cmp(breaker_status_o, 32'h0000_0004, "held");
    pulse(status_rd_i);
    cmp(breaker_sticky_o, 0, "sticky read");
    cmp(breaker_status_o, 32'h0000_0004, "live");
    reclose_enable_i = 1'b1;
    wait_for(0);
    cyc(2);
    cmp(line_o[2], 1, "reclosed");
    reclose_enable_i = 1'b0;
    $display("test trip done");
    ovl = 32'h0000_000d;
    write_out(32'hffff_ffff);
    wait_for(32'h0000_002d);
    cmp(breaker_status_o, 32'h0000_002d, "own limit");
    ovl = '0;
    breaker_mask_i = 32'h0000_0005;
    pulse(breaker_reset_i);
    cmp(breaker_status_o, 32'h0000_0028, "mask");
    pulse(session_start_i);
    cmp(breaker_status_o, 0, "session");
    cmp(running_o, 0, "stopped");
    tcfg.monitor_sample_rate = 16'h0004;
    lower_current_threshold_i = 12'h200;
    wait_for(32'hffff_f0ff);
    cmp(breaker_status_o, 32'hffff_f0ff, "under");
    lower_current_threshold_i = 12'h000;
    tcfg.monitor_sample_rate = 16'h0001;
    breaker_mask_i = 32'hffff_ffff;
    pulse(breaker_reset_i);
    cmp(breaker_status_o, 0, "all reset");
    $display("test breaker done");
    cyc(20);
    for (int k = 0; k < 8; k++) begin
      diag_sel_i = 6'(k);
      cyc(2);
      cmp({diag_valid_o, diag_data_o}, 32'h0000_1100, "current");
      cmp({diag_valid_r, diag_data_r}, 32'h0000_1100, "red cur");
      diag_sel_i = 6'(k + 32);
      cyc(2);
      cmp({diag_valid_o, diag_data_o}, 32'h0000_1600, "voltage");
      cmp({diag_valid_r, diag_data_r}, 32'h0000_0000, "red volt");
    end
    $display("test diag done");
    final_report();
  end
endmodule
